// >>> rtl/black_average_gain.sv
// black-average scaling: divide the window sum by its sample count, apply gain
`timescale 1ns/1ps
`default_nettype none
module black_average_gain
    import black_clamp_pkg::*;
(
    input wire logic [SUM_W-1:0] sum_in,
    input wire logic [CODE_W-1:0] pix_code,
    input wire logic [CODE_W-1:0] line_code,
    input wire logic [GAIN_W-1:0] gain,
    output logic [PIX_W-1:0] level_out
);
    logic [3:0] shift_amt;
    logic [SUM_W-1:0] avg;
    logic [SUM_W+GAIN_W-1:0] prod;
    logic [SUM_W+GAIN_W-1:0] scaled;

    // counts are powers of two, so the divide is a shift by both codes
    always_comb begin
        shift_amt = 4'({1'b0, pix_code} + {1'b0, line_code});
        avg = sum_in >> shift_amt;
        prod = (SUM_W + GAIN_W)'(avg) * (SUM_W + GAIN_W)'(gain); // see RQ5
        scaled = prod >> GAIN_FRAC;
        // saturate: a gain near two can overflow the pixel range
        if (|scaled[SUM_W+GAIN_W-1:PIX_W]) begin
            level_out = '1;
        end else begin
            level_out = scaled[PIX_W-1:0];
        end
    end
endmodule // black_average_gain
`default_nettype wire

// >>> rtl/black_clamp_pkg.sv
// constants, register map and field layout for the black-level clamp stage
// Notes on behaviour
// RQ1: with the clamp enable set, pixels are clamped by the optical-black average, the enable being taken up only at vertical sync.
// RQ2: a 3-bit code picks 1, 2, 4, 8 or 16 black pixels per line for the average; codes 5 to 7 are reserved.
// RQ3: a 3-bit code picks 1, 2, 4, 8 or 16 black lines for the average; higher codes are reserved.
// RQ4: the first black sample of a line lies a programmable 15-bit count of pixel clocks after horizontal sync starts.
// RQ5: the black average is multiplied by a 5-bit unsigned gain with four fraction bits, from zero to just under two.
// RQ6: with clamping off, a programmable 14-bit DC level is subtracted from every sample.
// RQ7: in 8-bit YUV input mode (code 2) or embedded-sync mode, negative DC-subtraction results are not clipped to zero.
// RQ8: each colour-pattern entry is a 2-bit code: 0 red, 1 green on red row, 2 green on blue row, 3 blue.
// RQ9: the pattern register holds sixteen 2-bit entries, line L pixel P at bits 8L+2P+1 down to 8L+2P.
// RQ10: with clamping on, the gained black average replaces the DC level and is refreshed from the window every frame.
// RQ11: in other raw input modes, negative DC-subtraction results saturate to zero.
package black_clamp_pkg;
    // word byte addresses on the wishbone slave
    localparam logic [3:0] ADDR_CLAMP_SETTINGS = 4'h0;
    localparam logic [3:0] ADDR_DC_LEVEL = 4'h4;
    localparam logic [3:0] ADDR_COLOR_PATTERN = 4'h8;
    localparam logic [3:0] ADDR_MODE_CONFIG = 4'hC;
    localparam logic [3:0] ADDR_BLACK_STATUS = 4'h0; // status sits at word 4 (0x10)
    localparam logic [4:0] ADDR_STATUS_FULL = 5'h10;
    // black_clamp_settings fields
    localparam int CLAMP_EN_BIT = 31;
    localparam int PIX_CODE_LSB = 28;
    localparam int LINE_CODE_LSB = 25;
    localparam int START_LSB = 10;
    localparam int GAIN_LSB = 0;
    localparam logic [31:0] CLAMP_WRITE_MASK = 32'hFFFF_FC1F; // bits 9-5 read zero
    localparam logic [31:0] DC_WRITE_MASK = 32'h0000_3FFF;
    localparam logic [31:0] MODE_WRITE_MASK = 32'h0000_0013;
    // mode_config fields: input format in bits 1-0, embedded sync enable in bit 4
    localparam int FORMAT_LSB = 0;
    localparam int EMBED_BIT = 4;
    localparam logic [1:0] FORMAT_YUV8 = 2'h2;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    // widths
    localparam int PIX_W = 14;
    localparam int START_W = 15;
    localparam int GAIN_W = 5;
    localparam int GAIN_FRAC = 4;
    localparam int CODE_W = 3;
    localparam logic [2:0] CODE_MAX = 3'h4;
    localparam int SUM_W = PIX_W + 8; // up to 256 samples
    // colour codes
    typedef enum logic [1:0] {
        COLOR_RED = 2'h0,
        COLOR_GREEN_RED_ROW = 2'h1,
        COLOR_GREEN_BLUE_ROW = 2'h2,
        COLOR_BLUE = 2'h3
    } color_type;
endpackage

// >>> rtl/black_clamp_stage.sv
// black-level clamp stage: wishbone registers, black sampling, clamp datapath
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module black_clamp_stage
    import black_clamp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sensor side, asynchronous pins
    input wire logic [PIX_W-1:0] sensor_data,
    input wire logic sensor_valid,
    input wire logic horizontal_sync,
    input wire logic vertical_sync,
    // processed pixel stream
    output logic [PIX_W-1:0] pixel_out,
    output logic pixel_out_valid,
    output logic [1:0] pixel_color
);
    localparam int SYNC_W = PIX_W + 3;

    logic [31:0] clamp_settings_r;
    logic [31:0] dc_level_r;
    logic [31:0] color_pattern_r;
    logic [31:0] mode_config_r;
    logic black_clamp_enable_r;
    logic [PIX_W-1:0] black_level_r;
    logic [SUM_W-1:0] black_sum_r;
    logic [START_W:0] pix_cnt_r;
    logic [4:0] line_cnt_r;
    logic [4:0] win_cnt_r;
    logic [1:0] line_idx_r;
    logic [1:0] pix_idx_r;
    logic [SYNC_W-1:0] sync_bus;
    logic [SYNC_W-1:0] rise_bus;
    logic [PIX_W-1:0] data_s;
    logic valid_s;
    logic hs_rise;
    logic vs_rise;
    logic [PIX_W-1:0] gained_level;
    logic [PIX_W-1:0] sub_level;
    logic [PIX_W:0] diff;
    logic no_clip;
    logic in_window;
    logic [4:0] pix_needed;
    logic [4:0] line_needed;
    logic [START_W:0] start_pix;
    logic [CODE_W-1:0] pix_code;
    logic [CODE_W-1:0] line_code;
    logic bus_req;
    logic [31:0] rd_word;

    // reserved codes fall back to the largest documented count
    function automatic logic [CODE_W-1:0] legal_code(input logic [CODE_W-1:0] code);
        legal_code = (code > CODE_MAX) ? CODE_MAX : code;
    endfunction

    function automatic logic [4:0] code_count(input logic [CODE_W-1:0] code);
        code_count = 5'(5'h1 << code);
    endfunction

    // byte-lane merge of a write into a register, masking reserved bits
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = res & mask;
    endfunction

    pixel_sync_in #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .srst(srst),
        .async_in({sensor_data, sensor_valid, horizontal_sync, vertical_sync}),
        .sync_out(sync_bus),
        .rise_out(rise_bus)
    );

    assign data_s = sync_bus[SYNC_W-1:3];
    assign valid_s = sync_bus[2];
    assign hs_rise = rise_bus[1];
    assign vs_rise = rise_bus[0];

    assign pix_code = legal_code(clamp_settings_r[PIX_CODE_LSB +: CODE_W]); // see RQ2
    assign line_code = legal_code(clamp_settings_r[LINE_CODE_LSB +: CODE_W]); // see RQ3
    assign pix_needed = code_count(pix_code);
    assign line_needed = code_count(line_code);
    assign start_pix = {1'b0, clamp_settings_r[START_LSB +: START_W]};

    black_average_gain u_gain (
        .sum_in(black_sum_r),
        .pix_code(pix_code),
        .line_code(line_code),
        .gain(clamp_settings_r[GAIN_LSB +: GAIN_W]),
        .level_out(gained_level)
    );

    // wishbone: one-cycle ack, dropped the cycle after it is given
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // register writes land at the edge where the master sees ack high
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clamp_settings_r <= REG_RESET;
            dc_level_r <= REG_RESET;
            color_pattern_r <= REG_RESET;
            mode_config_r <= REG_RESET;
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin
            case (wb_adr_i)
                {1'b0, ADDR_CLAMP_SETTINGS}: begin
                    clamp_settings_r <= merge(clamp_settings_r, wb_dat_i, wb_sel_i,
                                              CLAMP_WRITE_MASK);
                end
                {1'b0, ADDR_DC_LEVEL}: begin
                    dc_level_r <= merge(dc_level_r, wb_dat_i, wb_sel_i, DC_WRITE_MASK); // see RQ6
                end
                {1'b0, ADDR_COLOR_PATTERN}: begin
                    color_pattern_r <= merge(color_pattern_r, wb_dat_i, wb_sel_i, '1); // see RQ9
                end
                {1'b0, ADDR_MODE_CONFIG}: begin
                    mode_config_r <= merge(mode_config_r, wb_dat_i, wb_sel_i, MODE_WRITE_MASK);
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero and are still acknowledged
    always_comb begin
        case (wb_adr_i)
            {1'b0, ADDR_CLAMP_SETTINGS}: rd_word = clamp_settings_r;
            {1'b0, ADDR_DC_LEVEL}: rd_word = dc_level_r;
            {1'b0, ADDR_COLOR_PATTERN}: rd_word = color_pattern_r;
            {1'b0, ADDR_MODE_CONFIG}: rd_word = mode_config_r;
            ADDR_STATUS_FULL: rd_word = {black_clamp_enable_r, 17'h0_0000, black_level_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req) begin
            wb_dat_o <= rd_word;
        end
    end

    // enable is taken into the datapath only at vertical sync
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            black_clamp_enable_r <= 1'b0;
        end else if (vs_rise) begin
            black_clamp_enable_r <= clamp_settings_r[CLAMP_EN_BIT]; // see RQ1
        end
    end

    // pixel counter from horizontal sync, line counter from vertical sync
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pix_cnt_r <= '0;
            pix_idx_r <= 2'h0;
        end else if (hs_rise) begin
            pix_cnt_r <= '0; // see RQ4
            pix_idx_r <= 2'h0;
        end else begin
            if (!(&pix_cnt_r)) begin
                pix_cnt_r <= pix_cnt_r + 1'b1;
            end
            if (valid_s) begin
                pix_idx_r <= pix_idx_r + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            line_cnt_r <= 5'h00;
            line_idx_r <= '1;
        end else if (vs_rise) begin
            line_cnt_r <= 5'h00;
            line_idx_r <= '1; // first hsync of a frame steps this to pattern line 0
        end else if (hs_rise) begin
            // saturates so the window closes after the chosen line count
            if (line_cnt_r != 5'h1F) begin
                line_cnt_r <= line_cnt_r + 5'h01;
            end
            line_idx_r <= line_idx_r + 2'h1;
        end
    end

    // the window: first lines after vsync, pixels from the start offset
    always_comb begin
        in_window = valid_s && (line_cnt_r != 5'h00) && (line_cnt_r <= line_needed)
            && (pix_cnt_r >= start_pix) // see RQ4
            && (win_cnt_r < pix_needed); // see RQ2
    end

    // samples taken on this line; gaps in valid must not shorten the window
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            win_cnt_r <= 5'h00;
        end else if (hs_rise) begin
            win_cnt_r <= 5'h00;
        end else if (in_window) begin
            win_cnt_r <= win_cnt_r + 5'h01;
        end
    end

    // accumulate the window each frame; latch the level at frame end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            black_sum_r <= '0;
            black_level_r <= '0;
        end else if (vs_rise) begin
            black_level_r <= gained_level; // see RQ10
            black_sum_r <= '0;
        end else if (in_window) begin
            black_sum_r <= black_sum_r + SUM_W'(data_s); // see RQ2
        end
    end

    // pick the level to subtract and whether clipping applies
    always_comb begin
        sub_level = black_clamp_enable_r ? black_level_r
                                         : dc_level_r[PIX_W-1:0]; // see RQ10
        no_clip = (mode_config_r[FORMAT_LSB +: 2] == FORMAT_YUV8)
            || mode_config_r[EMBED_BIT]; // see RQ7
        diff = {1'b0, data_s} - {1'b0, sub_level};
    end

    // output pixel; a wrapped result is kept only in the no-clip modes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pixel_out <= '0;
            pixel_out_valid <= 1'b0;
            pixel_color <= COLOR_RED;
        end else begin
            pixel_out_valid <= valid_s;
            if (diff[PIX_W] && !no_clip) begin
                pixel_out <= '0; // see RQ11
            end else begin
                pixel_out <= diff[PIX_W-1:0]; // see RQ6
            end
            // colour lookup: line L pixel P at bits 8L+2P+1..8L+2P
            pixel_color <= color_pattern_r[{line_idx_r, pix_idx_r, 1'b0} +: 2]; // see RQ8
        end
    end
endmodule // black_clamp_stage
`default_nettype wire

// >>> rtl/pixel_sync_in.sv
// two-flop synchroniser for the sensor pins plus a sync edge detector
`timescale 1ns/1ps
`default_nettype none
module pixel_sync_in
    import black_clamp_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out,
    output logic [WIDTH-1:0] rise_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] stage_r;
    logic [WIDTH-1:0] prev_r;

    // first stage is read only by the second
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta_r <= '0;
            stage_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= async_in;
            stage_r <= meta_r;
            prev_r <= stage_r;
        end
    end

    assign sync_out = stage_r;
    assign rise_out = stage_r & ~prev_r;
endmodule // pixel_sync_in
`default_nettype wire

// >>> verif/black_clamp_monitor.sv
// concurrent checks on the black-level clamp stage ports
`timescale 1ns/1ps
`default_nettype none
module black_clamp_monitor
    import black_clamp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [PIX_W-1:0] sensor_data,
    input wire logic sensor_valid,
    input wire logic [PIX_W-1:0] pixel_out,
    input wire logic pixel_out_valid
);
    logic [31:0] pattern_r;
    logic raw_r;
    // shadows from acked writes; full-word writes only, byte lanes are not tracked
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pattern_r <= REG_RESET;
            raw_r <= 1'b1;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 5'h08) begin
            pattern_r <= wb_dat_i;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 5'h0C) begin
            raw_r <= wb_dat_i[1:0] != FORMAT_YUV8 && !wb_dat_i[EMBED_BIT];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_answers: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered next cycle");
    chk_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_valid_delay: assert property (pixel_out_valid == $past(sensor_valid, 3))
        else $error("output valid not three cycles after input");
    chk_clamp_gap_zero: assert property
        ((wb_ack_o && !wb_we_i && wb_adr_i == 5'h00) |-> wb_dat_o[9:5] == 5'h00)
        else $error("clamp settings gap bits not zero");
    chk_dc_upper_zero: assert property
        ((wb_ack_o && !wb_we_i && wb_adr_i == 5'h04) |-> wb_dat_o[31:14] == 18'h0)
        else $error("dc level upper bits not zero");
    chk_pattern_readback: assert property
        ((wb_ack_o && !wb_we_i && wb_adr_i == 5'h08) |-> wb_dat_o == pattern_r)
        else $error("pattern word differs from last write");
    chk_raw_floor: assert property
        ((pixel_out_valid && raw_r) |-> pixel_out <= $past(sensor_data, 3))
        else $error("raw result above its input sample");
endmodule // black_clamp_monitor
`default_nettype wire

// >>> verif/sensor_model.sv
// behavioural image sensor driving sync pulses and pixel samples
`timescale 1ns/1ps
`default_nettype none
module sensor_model
    import black_clamp_pkg::*;
(
    input wire logic clk_sys,
    output logic [PIX_W-1:0] sensor_data,
    output logic sensor_valid,
    output logic horizontal_sync,
    output logic vertical_sync
);
    // pins idle low, data parked on a pattern so stale values never look valid
    initial begin
        sensor_data = 14'h2AAA;
        sensor_valid = 1'b0;
        horizontal_sync = 1'b0;
        vertical_sync = 1'b0;
    end
    // two-cycle vertical pulse, long enough for the input synchroniser
    task automatic frame_start();
        vertical_sync <= 1'b1;
        repeat (2) @(posedge clk_sys);
        vertical_sync <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask
    // one line: gap 0 streams pixels back to back, otherwise stalls between them
    task automatic send_line(input logic [PIX_W-1:0] pix [$], input int gap);
        horizontal_sync <= 1'b1;
        repeat (2) @(posedge clk_sys);
        horizontal_sync <= 1'b0;
        foreach (pix[i]) begin
            sensor_valid <= 1'b1;
            sensor_data <= pix[i];
            @(posedge clk_sys);
            if (gap > 0) begin
                sensor_valid <= 1'b0;
                sensor_data <= ~pix[i];
                repeat (gap) @(posedge clk_sys);
            end
        end
        sensor_valid <= 1'b0;
        sensor_data <= ~sensor_data;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule // sensor_model
`default_nettype wire

// >>> verif/test_black_clamp_stage.sv
// self-checking testbench for the black-level clamp stage
`timescale 1ns/1ps
`default_nettype none
module test_black_clamp_stage
    import black_clamp_pkg::*;
;
    logic clk_sys;
    logic srst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [4:0] wb_adr_i = 5'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, seed = 32'h3D, pat = 32'h0;
    logic wb_ack_o, sensor_valid, horizontal_sync, vertical_sync, pixel_out_valid;
    logic [PIX_W-1:0] sensor_data, pixel_out;
    logic [1:0] pixel_color;
    logic [15:0] exp_q [$];
    int n_checks = 0, n_mismatch = 0, cycles = 0, line_no = 0;
    black_clamp_stage dut (.clk_sys(clk_sys), .srst(srst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sensor_data(sensor_data), .sensor_valid(sensor_valid),
        .horizontal_sync(horizontal_sync), .vertical_sync(vertical_sync),
        .pixel_out(pixel_out), .pixel_out_valid(pixel_out_valid), .pixel_color(pixel_color));
    sensor_model sens (.clk_sys(clk_sys), .sensor_data(sensor_data),
        .sensor_valid(sensor_valid), .horizontal_sync(horizontal_sync),
        .vertical_sync(vertical_sync));
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    // one classic cycle; request held until ack is sampled, then one idle cycle
    task automatic xfer(input logic [4:0] a, input logic w, input logic [31:0] d,
        output logic [31:0] q);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic frame();
        sens.frame_start();
        line_no = 0;
    endtask
    // with note set, note colour and level-subtracted value of each sample, then send the line
    task automatic run_line(input int n, input logic [13:0] base, input bit note,
        input logic [13:0] lvl, input bit clip);
        logic [13:0] pix [$];
        logic [13:0] d;
        for (int p = 0; p < n; p++) begin
            d = note ? 14'(rnd()) | base : base;
            pix.push_back(d);
            if (note) exp_q.push_back({pat[8 * (line_no % 4) + 2 * (p % 4) +: 2],
                (clip && d < lvl) ? 14'h0 : d - lvl});
        end
        sens.send_line(pix, line_no % 2);
        line_no++;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // samples without a note (black measurement frames) are not compared
    always @(posedge clk_sys) begin
        if (pixel_out_valid === 1'b1 && exp_q.size() > 0)
            check("pixel", 32'(exp_q.pop_front()), {16'h0, pixel_color, pixel_out});
    end
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        logic [31:0] q, r;
        logic [31:0] msk [4];
        logic [4:0] g;
        logic [13:0] dc;
        msk = '{CLAMP_WRITE_MASK, DC_WRITE_MASK, 32'hFFFF_FFFF, MODE_WRITE_MASK};
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            if (i == 0) r[31] = 1'b0;
            if (i == 2) pat = r;
            xfer(5'(4 * i), 1'b0, 32'h0, q);
            check("reset", REG_RESET, q);
            xfer(5'(4 * i), 1'b1, r, q);
            xfer(5'(4 * i), 1'b0, 32'h0, q);
            check("readback", r & msk[i], q);
        end
        xfer(5'h14, 1'b1, rnd(), q);
        xfer(5'h14, 1'b0, 32'h0, q);
        check("unmapped", 32'h0, q);
        $display("test registers done");
        dc = 14'h1000 | 14'(rnd() & 32'h0FFF);
        xfer(5'h04, 1'b1, {18'h0, dc}, q);
        // raw clips at zero, 8-bit yuv and embedded sync wrap
        for (int m = 0; m < 3; m++) begin
            xfer(5'h0C, 1'b1, m == 1 ? 32'h2 : m == 2 ? 32'h10 : 32'h0, q);
            frame();
            for (int l = 0; l < 5; l++) run_line(6, 14'h0, 1'b1, dc, m == 0);
            check("drained", 32'h0, 32'(exp_q.size()));
        end
        $display("test dc subtraction done");
        xfer(5'h0C, 1'b1, 32'h0, q);
        frame();
        // gain kept at or below one so a flat black frame never goes negative
        for (int k = 0; k < 5; k++) begin
            g = 5'(rnd() % 17);
            xfer(5'h00, 1'b1, {1'b1, k[2:0], k[2:0], 20'h0, g}, q);
            frame();
            for (int l = 0; l < (1 << k); l++) run_line(20, 14'h0100, 1'b0, 14'h0, 1'b0);
            frame();
            xfer(5'h10, 1'b0, 32'h0, q);
            check("status", {1'b1, 17'h0, 14'(16 * g)}, q & 32'h8000_3FFF);
        end
        run_line(8, 14'h2000, 1'b1, 14'(16 * g), 1'b1);
        xfer(5'h00, 1'b1, 32'h0, q);
        run_line(8, 14'h2000, 1'b1, 14'(16 * g), 1'b1);
        frame();
        run_line(8, 14'h2000, 1'b1, dc, 1'b1);
        check("drained", 32'h0, 32'(exp_q.size()));
        $display("test clamp done");
        final_report();
    end
endmodule // test_black_clamp_stage
bind black_clamp_stage black_clamp_monitor mon (.clk_sys(clk_sys), .srst(srst),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sensor_data(sensor_data), .sensor_valid(sensor_valid), .pixel_out(pixel_out),
    .pixel_out_valid(pixel_out_valid));
`default_nettype wire
